// [src/jbs_tap.sv]
`timescale 1ns/1ps
`default_nettype none
`include "jbs_regs.svh"

module jbs_tap #(
  parameter int N_IO = 4,
  // Identification fields; values are arbitrary.
  parameter logic [10:0] MAKER_ID = 11'h055,
  parameter logic [15:0] PART_ID = 16'h1234,
  parameter logic [3:0] VERSION = 4'h1,
  // User code word; value is arbitrary.
  parameter logic [31:0] USER_CODE = 32'h0000_0000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic tck,
  input wire jbs_pkg::jbs_jtag_in_type jtag_in,
  input wire logic lp_freeze,
  input wire logic [N_IO-1:0] pad_in,
  input wire logic [N_IO-1:0] core_out,
  input wire logic [N_IO-1:0] core_oe,
  output var jbs_pkg::jbs_jtag_out_type jtag_out,
  output logic [N_IO-1:0] pad_out,
  output logic [N_IO-1:0] pad_oe,
  output logic [N_IO-1:0] core_in,
  output logic [`JBS_IR_W-1:0] ir_core
);
  import jbs_pkg::*;

  localparam int BSR_W = `JBS_CELLS_PER_IO * N_IO;
  localparam logic [`JBS_ID_W-1:0] ID_WORD =
    {VERSION, PART_ID, MAKER_ID, `JBS_ID_LSB};

  // ========================================================
  // State of the test clock domain
  // ========================================================
  typedef struct packed {
    jbs_tap_state_type st;
    logic [`JBS_IR_W-1:0] ir_sh;
    logic [`JBS_IR_W-1:0] ir;
    logic byp;
    logic [`JBS_ID_W-1:0] id_sh;
    logic frz1;
    logic frz2;
    logic tgl;
  } jbs_tck_state_type;

  localparam jbs_tck_state_type T_RST = '{
    st: st_tlr,
    ir: `JBS_IR_RESET,
    ir_sh: `JBS_IR_CAPTURE,
    byp: `JBS_BYP_CAPTURE,
    id_sh: ID_WORD,
    frz1: 1'b0,
    frz2: 1'b0,
    tgl: 1'b0
  };

  // ========================================================
  // State of the core clock domain
  // ========================================================
  typedef struct packed {
    logic tgl1;
    logic tgl2;
    logic seen;
    logic [`JBS_IR_W-1:0] ir;
    logic [BSR_W-1:0] upd;
    logic [N_IO-1:0] pin1;
    logic [N_IO-1:0] pin2;
    logic [N_IO-1:0] pad_out;
    logic [N_IO-1:0] pad_oe;
    logic [N_IO-1:0] core_in;
  } jbs_ref_state_type;

  localparam jbs_ref_state_type R_RST = '{
    ir: `JBS_IR_RESET,
    default: '0
  };

  jbs_tck_state_type t_reg;
  jbs_tck_state_type t_next;
  jbs_jtag_out_type o_reg;
  jbs_jtag_out_type o_next;
  jbs_ref_state_type r_reg;
  jbs_ref_state_type r_next;

  logic tap_rst_b;
  logic sel_bsr;
  logic sel_id;
  logic sel_user;
  logic shifting;
  logic lsb_out;
  jbs_cell_ctl_type cell_ctl;
  logic [N_IO:0] chain;
  logic [BSR_W-1:0] bsr_upd;

  // ========================================================
  // Test reset
  // ========================================================
  // Either the scan reset pin or the power-on reset clears the
  // controller at once, with no clock edge needed.
  assign tap_rst_b = jtag_in.trst_b & rst_b;

  // ========================================================
  // Instruction decode and strobes
  // ========================================================
  // Only the boundary, identification and user registers are
  // addressed; every other code falls through to bypass.
  always_comb begin
    sel_bsr = (t_reg.ir == `JBS_OP_EXTEST) ||
              (t_reg.ir == `JBS_OP_SAMPLE);
    sel_id = (t_reg.ir == `JBS_OP_IDCODE);
    sel_user = (t_reg.ir == `JBS_OP_USERCODE);
    shifting = (t_reg.st == st_shift_dr) ||
               (t_reg.st == st_shift_ir);
    cell_ctl.capture = sel_bsr && (t_reg.st == st_cap_dr);
    cell_ctl.shift = sel_bsr && (t_reg.st == st_shift_dr);
    cell_ctl.update = sel_bsr && (t_reg.st == st_upd_dr);
    if (t_reg.st == st_shift_ir) begin
      lsb_out = t_reg.ir_sh[0];
    end else if (sel_bsr) begin
      lsb_out = chain[0];
    end else if (sel_id || sel_user) begin
      lsb_out = t_reg.id_sh[0];
    end else begin
      lsb_out = t_reg.byp;
    end
  end

  // ========================================================
  // Boundary chain
  // ========================================================
  // The serial input enters the highest group and leaves from
  // group zero.
  assign chain[N_IO] = jtag_in.tdi;

  generate
    for (genvar k = 0; k < N_IO; k++) begin : g_io
      jbs_bs_cell u_cell (
        .tck(tck),
        .tap_rst_b(tap_rst_b),
        .ctl(cell_ctl),
        .par_in({pad_in[k], core_out[k], core_oe[k]}),
        .si(chain[k+1]),
        .so(chain[k]),
        .par_out(bsr_upd[`JBS_CELLS_PER_IO*k +: `JBS_CELLS_PER_IO])
      );
    end
  endgenerate

  // ========================================================
  // Controller and scan registers
  // ========================================================
  // Next state follows TMS; the freeze input, once resynchronised,
  // pins the controller in reset so scan cannot start from it.
  always_comb begin
    t_next = t_reg;
    t_next.frz1 = lp_freeze;
    t_next.frz2 = t_reg.frz1;
    case (t_reg.st)
      st_tlr: begin
        t_next.st = jtag_in.tms ? st_tlr : st_run_idle;
      end
      st_run_idle: begin
        t_next.st = jtag_in.tms ? st_sel_dr : st_run_idle;
      end
      st_sel_dr: begin
        t_next.st = jtag_in.tms ? st_sel_ir : st_cap_dr;
      end
      st_cap_dr: begin
        t_next.st = jtag_in.tms ? st_exit1_dr : st_shift_dr;
      end
      st_shift_dr: begin
        t_next.st = jtag_in.tms ? st_exit1_dr : st_shift_dr;
      end
      st_exit1_dr: begin
        t_next.st = jtag_in.tms ? st_upd_dr : st_pause_dr;
      end
      st_pause_dr: begin
        t_next.st = jtag_in.tms ? st_exit2_dr : st_pause_dr;
      end
      st_exit2_dr: begin
        t_next.st = jtag_in.tms ? st_upd_dr : st_shift_dr;
      end
      st_upd_dr: begin
        t_next.st = jtag_in.tms ? st_sel_dr : st_run_idle;
      end
      st_sel_ir: begin
        t_next.st = jtag_in.tms ? st_tlr : st_cap_ir;
      end
      st_cap_ir: begin
        t_next.st = jtag_in.tms ? st_exit1_ir : st_shift_ir;
      end
      st_shift_ir: begin
        t_next.st = jtag_in.tms ? st_exit1_ir : st_shift_ir;
      end
      st_exit1_ir: begin
        t_next.st = jtag_in.tms ? st_upd_ir : st_pause_ir;
      end
      st_pause_ir: begin
        t_next.st = jtag_in.tms ? st_exit2_ir : st_pause_ir;
      end
      st_exit2_ir: begin
        t_next.st = jtag_in.tms ? st_upd_ir : st_shift_ir;
      end
      st_upd_ir: begin
        t_next.st = jtag_in.tms ? st_sel_dr : st_run_idle;
      end
      default: begin
        t_next.st = st_tlr;
      end
    endcase
    if (t_reg.frz2) begin
      t_next.st = st_tlr;
    end

    // Register actions of the present state.
    case (t_reg.st)
      st_tlr: begin
        t_next.ir = `JBS_IR_RESET;
      end
      st_cap_ir: begin
        t_next.ir_sh = `JBS_IR_CAPTURE;
      end
      st_shift_ir: begin
        t_next.ir_sh = {jtag_in.tdi, t_reg.ir_sh[`JBS_IR_W-1:1]};
      end
      st_upd_ir: begin
        t_next.ir = t_reg.ir_sh;
      end
      st_cap_dr: begin
        t_next.byp = `JBS_BYP_CAPTURE;
        if (sel_id) begin
          t_next.id_sh = ID_WORD;
        end else if (sel_user) begin
          t_next.id_sh = USER_CODE;
        end
      end
      st_shift_dr: begin
        t_next.byp = jtag_in.tdi;
        if (sel_id || sel_user) begin
          t_next.id_sh = {jtag_in.tdi, t_reg.id_sh[`JBS_ID_W-1:1]};
        end
      end
      default: begin
      end
    endcase

    // Any update, or a fall into reset, tells the core domain to
    // take a fresh copy of the instruction and update cells.
    if ((t_reg.st == st_upd_ir) || (t_reg.st == st_upd_dr) ||
        ((t_next.st == st_tlr) && (t_reg.st != st_tlr))) begin
      t_next.tgl = ~t_reg.tgl;
    end

    // Serial output prepared for the falling edge.
    o_next.tdo = shifting ? lsb_out : 1'b0;
    o_next.tdo_oe = shifting;
  end

  // Controller flops advance on the rising test clock.
  always_ff @(posedge tck or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      t_reg <= T_RST;
    end else begin
      t_reg <= t_next;
    end
  end

  // The serial output moves half a clock later than the shifters.
  always_ff @(negedge tck or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      o_reg <= '0;
    end else begin
      o_reg <= o_next;
    end
  end

  assign jtag_out = o_reg;

  // ========================================================
  // Core clock domain
  // ========================================================
  // The toggle passes two flops; the instruction and update
  // cells are stable long before it arrives and are copied once.
  always_comb begin
    r_next = r_reg;
    r_next.tgl1 = t_reg.tgl;
    r_next.tgl2 = r_reg.tgl1;
    r_next.seen = r_reg.tgl2;
    r_next.pin1 = pad_in;
    r_next.pin2 = r_reg.pin1;
    if (r_reg.tgl2 != r_reg.seen) begin
      r_next.ir = t_reg.ir;
      r_next.upd = bsr_upd;
    end
    for (int k = 0; k < N_IO; k++) begin
      if ((r_reg.ir == `JBS_OP_EXTEST) ||
          (r_reg.ir == `JBS_OP_CLAMP)) begin
        r_next.pad_out[k] =
          r_reg.upd[`JBS_CELLS_PER_IO*k + `JBS_CELL_OUT];
        r_next.pad_oe[k] =
          r_reg.upd[`JBS_CELLS_PER_IO*k + `JBS_CELL_EN];
      end else begin
        r_next.pad_out[k] = core_out[k];
        r_next.pad_oe[k] = core_oe[k];
      end
      if (r_reg.ir == `JBS_OP_HIGHZ) begin
        r_next.pad_oe[k] = 1'b0;
      end
      if (r_reg.ir == `JBS_OP_EXTEST) begin
        r_next.core_in[k] =
          r_reg.upd[`JBS_CELLS_PER_IO*k + `JBS_CELL_IN];
      end else begin
        r_next.core_in[k] = r_reg.pin2[k];
      end
    end
  end

  // Core domain flops.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= R_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pad_out = r_reg.pad_out;
  assign pad_oe = r_reg.pad_oe;
  assign core_in = r_reg.core_in;
  assign ir_core = r_reg.ir;

  // ========================================================
  // Checks
  // ========================================================
  sequence s_tms_high5;
    jtag_in.tms [*5];
  endsequence

  property p_tms_reset;
    @(posedge tck) disable iff (!tap_rst_b)
    s_tms_high5 |=> t_reg.st == st_tlr;
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("Five TMS-high clocks did not reach reset.");

  property p_tlr_exit;
    @(posedge tck) disable iff (!tap_rst_b)
    (t_reg.st == st_tlr && !jtag_in.tms && !t_reg.frz1
      && !t_reg.frz2) |=> t_reg.st == st_run_idle;
  endproperty
  a_tlr_exit: assert property (p_tlr_exit)
    else $error("Reset state did not leave on TMS low.");

  property p_freeze;
    @(posedge tck) disable iff (!tap_rst_b)
    t_reg.frz2 |=> t_reg.st == st_tlr;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Controller left reset while frozen.");

  property p_byp_cap;
    @(posedge tck) disable iff (!tap_rst_b)
    (t_reg.st == st_cap_dr && !sel_bsr && !sel_id && !sel_user)
      |=> !t_reg.byp;
  endproperty
  a_byp_cap: assert property (p_byp_cap)
    else $error("Bypass flop did not capture zero.");

  sequence s_id_capture;
    t_reg.st == st_cap_dr && sel_id;
  endsequence

  property p_id_cap;
    @(posedge tck) disable iff (!tap_rst_b)
    s_id_capture |=> t_reg.id_sh == ID_WORD && t_reg.id_sh[0];
  endproperty
  a_id_cap: assert property (p_id_cap)
    else $error("Identification word not captured.");

  property p_user_cap;
    @(posedge tck) disable iff (!tap_rst_b)
    (t_reg.st == st_cap_dr && sel_user) |=> t_reg.id_sh == USER_CODE;
  endproperty
  a_user_cap: assert property (p_user_cap)
    else $error("User code not captured.");

  property p_tdo_byp;
    @(negedge tck) disable iff (!tap_rst_b)
    (t_reg.st == st_shift_dr && !sel_bsr && !sel_id && !sel_user)
      |=> jtag_out.tdo_oe && jtag_out.tdo == $past(t_reg.byp);
  endproperty
  a_tdo_byp: assert property (p_tdo_byp)
    else $error("Serial output did not show the bypass flop.");

  property p_tdo_idle;
    @(negedge tck) disable iff (!tap_rst_b)
    !shifting |=> !jtag_out.tdo_oe && !jtag_out.tdo;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle)
    else $error("Serial output driven outside shift states.");

  property p_ir_core;
    @(posedge ref_clk) disable iff (!rst_b)
    (r_reg.tgl2 != r_reg.seen) |=> r_reg.ir == $past(t_reg.ir);
  endproperty
  a_ir_core: assert property (p_ir_core)
    else $error("Core copy of the instruction not updated.");

  property p_highz;
    @(posedge ref_clk) disable iff (!rst_b)
    (r_reg.ir == `JBS_OP_HIGHZ) |=> pad_oe == '0;
  endproperty
  a_highz: assert property (p_highz)
    else $error("Outputs enabled under the float instruction.");

  property p_extest;
    @(posedge ref_clk) disable iff (!rst_b)
    (r_reg.ir == `JBS_OP_EXTEST) |=>
      pad_out[0] == $past(r_reg.upd[`JBS_CELL_OUT]) &&
      pad_oe[0] == $past(r_reg.upd[`JBS_CELL_EN]);
  endproperty
  a_extest: assert property (p_extest)
    else $error("Pad not driven from update cells.");

endmodule
`default_nettype wire

// [src/jbs_regs.svh]
`ifndef JBS_REGS_SVH
`define JBS_REGS_SVH

// ==========================================================
// Instruction register size and opcodes
// ==========================================================
`define JBS_IR_W 8
`define JBS_OP_EXTEST 8'h00
`define JBS_OP_SAMPLE 8'h01
`define JBS_OP_CLAMP 8'h05
`define JBS_OP_HIGHZ 8'h07
`define JBS_OP_USERCODE 8'h0E
`define JBS_OP_IDCODE 8'h0F
`define JBS_OP_BYPASS 8'hFF

// ==========================================================
// Capture and reset values
// ==========================================================
// Pattern loaded into the instruction shifter in Capture-IR.
`define JBS_IR_CAPTURE 8'h01
// Instruction held after Test-Logic-Reset.
`define JBS_IR_RESET 8'h0F
// Value loaded into the bypass flop in Capture-DR.
`define JBS_BYP_CAPTURE 1'b0

// ==========================================================
// Identification register layout
// ==========================================================
`define JBS_ID_W 32
`define JBS_ID_LSB 1'b1
`define JBS_MAKER_W 11
`define JBS_PART_W 16
`define JBS_VER_W 4

// ==========================================================
// Boundary cells per I/O and their positions in a group
// ==========================================================
`define JBS_CELLS_PER_IO 3
`define JBS_CELL_IN 2
`define JBS_CELL_OUT 1
`define JBS_CELL_EN 0

`endif

// [src/jbs_pkg.sv]
package jbs_pkg;

  // ========================================================
  // Controller states
  // ========================================================
  typedef enum logic [3:0] {
    st_tlr, st_run_idle, st_sel_dr, st_cap_dr, st_shift_dr,
    st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir,
    st_pause_ir, st_exit2_ir, st_upd_ir
  } jbs_tap_state_type;

  // ========================================================
  // Carriers
  // ========================================================
  // Port pins driven by the host; mode and data are sampled on the test clock, the reset pin acts at once.
  typedef struct packed {
    logic tms;
    logic tdi;
    logic trst_b;
  } jbs_jtag_in_type;

  // Serial output pin and its enable.
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jbs_jtag_out_type;

  // Strobes from the controller to the boundary cells.
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jbs_cell_ctl_type;

endpackage

// [src/jbs_bs_cell.sv]
`timescale 1ns/1ps
`default_nettype none
`include "jbs_regs.svh"

// ==========================================================
// Three boundary cells of one I/O
// ==========================================================
module jbs_bs_cell (
  input wire logic tck,
  input wire logic tap_rst_b,
  input wire jbs_pkg::jbs_cell_ctl_type ctl,
  input wire logic [`JBS_CELLS_PER_IO-1:0] par_in,
  input wire logic si,
  output logic so,
  output logic [`JBS_CELLS_PER_IO-1:0] par_out
);
  import jbs_pkg::*;

  typedef struct packed {
    logic [`JBS_CELLS_PER_IO-1:0] s1;
    logic [`JBS_CELLS_PER_IO-1:0] s2;
    logic [`JBS_CELLS_PER_IO-1:0] sh;
    logic [`JBS_CELLS_PER_IO-1:0] up;
  } jbs_cell_state_type;

  jbs_cell_state_type c_reg;
  jbs_cell_state_type c_next;

  // Parallel inputs are resynchronised, then captured, shifted
  // toward the output end or copied to the update stage.
  always_comb begin
    c_next = c_reg;
    c_next.s1 = par_in;
    c_next.s2 = c_reg.s1;
    if (ctl.capture) begin
      c_next.sh = c_reg.s2;
    end else if (ctl.shift) begin
      c_next.sh = {si, c_reg.sh[`JBS_CELLS_PER_IO-1:1]};
    end
    if (ctl.update) begin
      c_next.up = c_reg.sh;
    end
  end

  // Cell flops on the test clock.
  always_ff @(posedge tck or negedge tap_rst_b) begin
    if (!tap_rst_b) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign so = c_reg.sh[0];
  assign par_out = c_reg.up;

  // ========================================================
  // Checks
  // ========================================================
  property p_cell_cap;
    @(posedge tck) disable iff (!tap_rst_b)
    ctl.capture |=> c_reg.sh == $past(c_reg.s2);
  endproperty
  a_cell_cap: assert property (p_cell_cap)
    else $error("Boundary cells did not capture parallel inputs.");

  // A bit needs three shift edges to cross the group, so the first
  // two shifts after a capture still show captured levels.
  property p_cell_shift;
    @(posedge tck) disable iff (!tap_rst_b)
    (ctl.shift && !ctl.capture) [*3] |=> so == $past(si, 3);
  endproperty
  a_cell_shift: assert property (p_cell_shift)
    else $error("Serial data did not pass the three cells.");

endmodule
`default_nettype wire

// [bench/jbs_host.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Scan host that drives the test port
// ==========================================================
module jbs_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_b,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // The test clock stands low between frames.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_b = 1'b1;
  end

  // One 12 ns test clock: pins change while the clock is low, the
  // answer is taken at the rising edge.
  task automatic step(input logic t, input logic d, output logic o,
      output logic oe);
    tms <= t;
    tdi <= d;
    #6;
    tck = 1'b1;
    o = tdo;
    oe = tdo_oe;
    #6;
    tck = 1'b0;
  endtask

  // Five clocks with mode high, then one low to reach Run-Idle.
  task automatic tlr();
    logic o;
    logic oe;
    repeat (5) step(1'b1, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
  endtask

  // Full scan from Run-Idle back to Run-Idle, data LSB first.
  // Outside the shift the data line toggles so no stale level lingers.
  task automatic scan(input logic ir, input logic [31:0] din,
      input int n, output logic [31:0] dout, output int n_oe);
    logic o;
    logic oe;
    dout = '0;
    n_oe = 0;
    step(1'b1, ~tdi, o, oe);
    if (ir) begin
      step(1'b1, ~tdi, o, oe);
    end
    step(1'b0, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      n_oe += (oe === 1'b1);
    end
    step(1'b1, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
  endtask

  // Test reset pulse with the test clock standing still.
  task automatic pulse_trst();
    trst_b = 1'b0;
    #20;
    trst_b = 1'b1;
  endtask
endmodule

`default_nettype wire

// [bench/jtag_boundary_scan_tap_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "jbs_regs.svh"

module jtag_boundary_scan_tap_bench;
  import jbs_pkg::*;

  // Identification values; they are arbitrary.
  localparam logic [10:0] MAKER = 11'h2a3;
  localparam logic [15:0] PART = 16'h5a5a;
  localparam logic [3:0] VER = 4'h3;
  localparam logic [31:0] UCODE = 32'hc0de_0007;
  localparam logic [31:0] ID_WORD = {VER, PART, MAKER, `JBS_ID_LSB};

  logic ref_clk, rst_b, lp_freeze, tck, tms, tdi, trst_b;
  logic [3:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
  logic [7:0] ir_core;
  logic [31:0] seed;
  jbs_jtag_in_type jtag_in;
  jbs_jtag_out_type jtag_out;
  int checks = 0;
  int n_mismatch = 0;
  int cycles = 0;

  assign jtag_in.tms = tms;
  assign jtag_in.tdi = tdi;
  assign jtag_in.trst_b = trst_b;

  jbs_tap #(.N_IO(4), .MAKER_ID(MAKER), .PART_ID(PART), .VERSION(VER),
      .USER_CODE(UCODE)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
      .tck(tck), .jtag_in(jtag_in), .lp_freeze(lp_freeze),
      .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe),
      .jtag_out(jtag_out), .pad_out(pad_out), .pad_oe(pad_oe),
      .core_in(core_in), .ir_core(ir_core));

  jbs_host host (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
      .tdo(jtag_out.tdo), .tdo_oe(jtag_out.tdo_oe));

  // Core clock at 25 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ========================================================
  // Helpers
  // ========================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Boundary capture: per I/O the input, output, enable cells.
  function automatic logic [11:0] cap_of();
    logic [11:0] c;
    for (int g = 0; g < 4; g++) begin
      c[3*g+2] = pad_in[g];
      c[3*g+1] = core_out[g];
      c[3*g] = core_oe[g];
    end
    return c;
  endfunction

  // Bits seen on the serial output during a 32-bit data scan.
  function automatic logic [31:0] exp_dr(input logic [7:0] op,
      input logic [31:0] din, input logic [11:0] cap);
    case (op)
      `JBS_OP_IDCODE: return ID_WORD;
      `JBS_OP_USERCODE: return UCODE;
      `JBS_OP_EXTEST, `JBS_OP_SAMPLE: return {din[19:0], cap};
      default: return {din[30:0], `JBS_BYP_CAPTURE};
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want,
      input string what);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic wait_ref(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Pad and core paths under each instruction.
  task automatic check_pads(input logic [7:0] op, input logic [11:0] u);
    logic [3:0] ui, uo, ue;
    for (int g = 0; g < 4; g++) begin
      ui[g] = u[3*g+2];
      uo[g] = u[3*g+1];
      ue[g] = u[3*g];
    end
    case (op)
      `JBS_OP_EXTEST: begin
        check(pad_out, uo, "extest out");
        check(pad_oe, ue, "extest oe");
        check(core_in, ui, "extest in");
      end
      `JBS_OP_CLAMP: begin
        check(pad_out, uo, "clamp out");
        check(pad_oe, ue, "clamp oe");
      end
      `JBS_OP_HIGHZ: check(pad_oe, 4'h0, "highz oe");
      default: begin
        check(pad_out, core_out, "func out");
        check(pad_oe, core_oe, "func oe");
        check(core_in, pad_in, "func in");
      end
    endcase
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ========================================================
  // Main sequence
  // ========================================================
  initial begin
    logic [7:0] ops [8];
    logic [31:0] dout, d;
    logic [11:0] upd, cap;
    logic o, oe;
    int n_oe;
    ops = '{`JBS_OP_SAMPLE, `JBS_OP_EXTEST, `JBS_OP_CLAMP, `JBS_OP_HIGHZ,
        `JBS_OP_USERCODE, `JBS_OP_IDCODE, `JBS_OP_BYPASS, 8'h3C};
    rst_b = 1'b0;
    lp_freeze = 1'b0;
    pad_in = 4'h0;
    core_out = 4'h0;
    core_oe = 4'h0;
    seed = 32'h3a32_0194;
    upd = '0;
    repeat (2) @(posedge ref_clk);
    host.step(1'b1, 1'b1, o, oe);
    repeat (18) @(posedge ref_clk);
    rst_b <= 1'b1;
    wait_ref(4);
    check(ir_core, `JBS_IR_RESET, "reset ir");
    check(jtag_out.tdo_oe, 1'b0, "idle oe");
    host.step(1'b0, 1'b0, o, oe);
    host.scan(1'b0, seed, 32, dout, n_oe);
    check(dout, ID_WORD, "id read");
    check(n_oe, 32, "shift oe");
    // Every opcode, each followed by a random data scan.
    foreach (ops[k]) begin
      @(posedge ref_clk);
      seed = xs(seed);
      {pad_in, core_out, core_oe} <= seed[11:0];
      wait_ref(2);
      cap = cap_of();
      host.scan(1'b1, {24'h0, ops[k]}, 8, dout, n_oe);
      check(dout[7:0], `JBS_IR_CAPTURE, "ir capture");
      wait_ref(10);
      check(ir_core, ops[k], "ir to core");
      seed = xs(seed);
      d = seed;
      host.scan(1'b0, d, 32, dout, n_oe);
      check(dout, exp_dr(ops[k], d, cap), "dr data");
      if (ops[k] == `JBS_OP_EXTEST || ops[k] == `JBS_OP_SAMPLE) begin
        upd = d[31:20];
      end
      wait_ref(10);
      check_pads(ops[k], upd);
    end
    // Five mode-high clocks from inside Shift-IR.
    host.step(1'b1, 1'b0, o, oe);
    host.step(1'b1, 1'b0, o, oe);
    host.step(1'b0, 1'b0, o, oe);
    host.step(1'b0, 1'b0, o, oe);
    host.tlr();
    host.scan(1'b0, 32'h0, 32, dout, n_oe);
    check(dout, ID_WORD, "five high");
    // Test reset with no clock after BYPASS was loaded.
    host.scan(1'b1, {24'h0, `JBS_OP_BYPASS}, 8, dout, n_oe);
    host.pulse_trst();
    host.step(1'b0, 1'b0, o, oe);
    host.scan(1'b0, 32'h0, 32, dout, n_oe);
    check(dout, ID_WORD, "trst");
    // Freeze holds the port out of test mode.
    @(posedge ref_clk);
    lp_freeze <= 1'b1;
    host.tlr();
    host.scan(1'b1, {24'h0, `JBS_OP_BYPASS}, 8, dout, n_oe);
    check(n_oe, 0, "freeze ir");
    host.scan(1'b0, 32'hffff_ffff, 32, dout, n_oe);
    check(n_oe, 0, "freeze dr");
    @(posedge ref_clk);
    lp_freeze <= 1'b0;
    host.tlr();
    host.scan(1'b0, 32'h0, 32, dout, n_oe);
    check(dout, ID_WORD, "after freeze");
    tally_and_finish();
  end
endmodule

`default_nettype wire
